// ### logic/cmpc_regs.svh
/*
 * Register offsets, field positions, reset values and bus codes of the
 * comparator control block.
 * Assumes inclusion by bare name from the top module and the bench.
 */
`ifndef CMPC_REGS_SVH
`define CMPC_REGS_SVH

// byte offsets on the AXI4-Lite slave
`define CMPC_OFF_CTRL     32'h0000_0000
`define CMPC_OFF_MASK     32'h0000_0004

// control and status field positions
`define CMPC_BIT_RSV_HI   15
`define CMPC_BIT_RSV_LO   11
`define CMPC_BIT_EN       10
`define CMPC_BIT_NSEL_HI  9
`define CMPC_BIT_NSEL_LO  8
`define CMPC_BIT_ROUTE_HI 7
`define CMPC_BIT_ROUTE_LO 6
`define CMPC_BIT_POL      5
`define CMPC_BIT_RESP_HI  4
`define CMPC_BIT_RESP_LO  3
`define CMPC_BIT_HYST     2
`define CMPC_BIT_RISE     1
`define CMPC_BIT_FALL     0

// reset values
`define CMPC_CTRL_RESET   16'h0000
`define CMPC_MASK_RESET   2'h0
`define CMPC_RSV_ZERO     5'h00

// AXI response codes
`define CMPC_RESP_OKAY    2'h0
`define CMPC_RESP_SLVERR  2'h2

`endif

// ### logic/cmpc_pkg.sv
/*
 * Types of the comparator control block: field encodings and the packed
 * layout of the control and status register.
 * Assumes cmpc_regs.svh for positions; the struct order matches them.
 */
package cmpc_pkg;

    typedef enum logic [1:0] {
        CMPC_NEG_HALF_SUPPLY   = 2'h0,  // analog_supply / 2
        CMPC_NEG_ANALOG_THREE  = 2'h1,  // analog_in_three pin
        CMPC_NEG_FIRST_CONVERT = 2'h2,  // first_converter_output
        CMPC_NEG_RESERVED      = 2'h3
    } cmpc_neg_t;

    typedef enum logic [1:0] {
        CMPC_ROUTE_RSV0 = 2'h0,
        CMPC_ROUTE_RSV1 = 2'h1,
        CMPC_ROUTE_PIN  = 2'h2,
        CMPC_ROUTE_IRQ  = 2'h3
    } cmpc_route_t;

    typedef enum logic [1:0] {
        CMPC_RESP_SLOW = 2'h0,
        CMPC_RESP_RSV1 = 2'h1,
        CMPC_RESP_RSV2 = 2'h2,
        CMPC_RESP_FAST = 2'h3
    } cmpc_resp_t;

    typedef struct packed {
        logic [4:0]  reserved;
        logic        comparator_enable_bit;
        cmpc_neg_t   negative_input_select;
        cmpc_route_t output_routing_select;
        logic        output_polarity_invert;
        cmpc_resp_t  response_time_select;
        logic        hysteresis_enable;
        logic        rising_edge_flag;
        logic        falling_edge_flag;
    } cmpc_ctrl_t;

    // settings handed to the analog comparator
    typedef struct packed {
        logic       comparator_enable_bit;
        logic       positive_input_share;
        cmpc_neg_t  negative_input_select;
        cmpc_resp_t response_time_select;
        logic       hysteresis_enable;
    } cmpc_analog_t;

endpackage : cmpc_pkg

// ### logic/cmpc_top.sv
/*
 * Control and status logic of an on-chip voltage comparator behind an
 * AXI4-Lite slave: settings for the analog core, polarity, output routing,
 * sticky edge flags, interrupt mask and one level interrupt.
 * Assumes the analog core delivers its raw decision asynchronously and that
 * the master keeps AXI4-Lite rules; one write and one read in flight.
 * Limitations: reserved select and response codes are stored as written,
 * routing codes 00 and 01 silence both the pin and the interrupt, and a
 * polarity flip while enabled is seen as an edge of the result. Software
 * must acknowledge each flag by writing a one to it.
 * The analog core itself, its timing and its hysteresis live outside.
 */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
// Notes on behaviour
// - Enable bit 10 switches comparator on/off.
// - Bits 9:8 choose negative input source.
// - Bits 7:6 route result to pin/IRQ.
// - Bit 5 inverts comparator output sense.
// - Bits 4:3 select slow or fast response.
// - Bit 2 adds about 7.5 mV hysteresis.
// - Rising edge sets sticky flag bit 1.
// - Writing one clears rising flag bit 1.
// - Falling edge sets sticky flag bit 0.
// - One 16-bit control/status register holds everything; the code keeps the interrupt mask in a word of its own at offset 4.
// - Positive input shared with analog_in_two pin.
`timescale 1ns/1ps

`include "cmpc_regs.svh"

module cmpc_top
(
    input  wire logic                aclk,           // 200 MHz system clock
    input  wire logic                aresetn,        // sync reset, active low
    input  wire logic [31:0]         s_axi_awaddr,   // write address
    input  wire logic                s_axi_awvalid,  // write address valid
    output logic                     s_axi_awready,  // write address ready
    input  wire logic [31:0]         s_axi_wdata,    // write data
    input  wire logic [3:0]          s_axi_wstrb,    // write byte enables
    input  wire logic                s_axi_wvalid,   // write data valid
    output logic                     s_axi_wready,   // write data ready
    output logic [1:0]               s_axi_bresp,    // write response code
    output logic                     s_axi_bvalid,   // write response valid
    input  wire logic                s_axi_bready,   // write response ready
    input  wire logic [31:0]         s_axi_araddr,   // read address
    input  wire logic                s_axi_arvalid,  // read address valid
    output logic                     s_axi_arready,  // read address ready
    output logic [31:0]              s_axi_rdata,    // read data
    output logic [1:0]               s_axi_rresp,    // read response code
    output logic                     s_axi_rvalid,   // read data valid
    input  wire logic                s_axi_rready,   // read data ready
    input  wire logic                comparator_raw, // analog decision, async
    output cmpc_pkg::cmpc_analog_t   analog_cfg,     // settings to analog core
    output logic                     comparator_output_pin, // external pin
    output logic                     irq             // level interrupt
);
    import cmpc_pkg::*;

    // register selector: bit 0 control/status, bit 1 mask, none = unmapped
    // only the word index is compared, so the two low address bits are
    // ignored and a byte address inside a word still hits that register
    function automatic logic [1:0] reg_sel(input logic [31:0] addr);
        logic [1:0] sel;
        sel    = 2'h0;
        sel[0] = (addr[31:2] == 30'(`CMPC_OFF_CTRL >> 2));
        sel[1] = (addr[31:2] == 30'(`CMPC_OFF_MASK >> 2));
        return sel;
    endfunction : reg_sel

    // register state
    // the mask is not part of the 16-bit register; it sits in a word of its
    // own so that the control/status layout keeps its fixed shape
    cmpc_ctrl_t  comparator_control_status;   // the one 16-bit register
    logic [1:0]  irq_mask;                    // same layout as the flags

    // input synchroniser and edge history
    // the raw decision is never read before the second flop, so a
    // metastable first stage cannot reach the flags or the pin
    logic        raw_meta;
    logic        raw_sync;
    logic        result_prev;

    // write channel holding stages
    // each channel has its own one-deep stage; that is what lets address
    // and data arrive in either order without a combinational path from
    // valid to ready
    logic        aw_held;
    logic [31:0] aw_addr_q;
    logic        w_held;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;

    // read channel stage
    // one read in flight at most, so a single stage is enough; data are
    // captured when the address is taken, not when rready comes
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // pin output flop
    // registered so the pad sees no decode glitches from routing changes;
    // the price is one more cycle between the decision and the pad
    logic        pin_q;

    // decode and handshake terms
    // everything below is combinational and settles within the cycle;
    // the only state lives in the always_ff blocks at the end
    logic [1:0]  wr_sel;
    logic [1:0]  rd_sel;
    logic        do_write;
    logic        do_read;
    logic        wr_ctrl_lo;
    logic        wr_ctrl_hi;
    logic        wr_mask;
    logic        result;
    logic        enabled;
    logic [1:0]  flag_set;
    logic [1:0]  flag_clr;
    logic [1:0]  next_flag;
    logic [2:0]  next_cfg_hi;
    logic [5:0]  next_cfg_lo;
    cmpc_ctrl_t  next_ctrl;
    logic [1:0]  next_mask;
    logic [31:0] read_word;
    logic        route_pin;
    logic        route_irq;

    // a write happens once address and data are both held and the
    // previous response has gone; holding each channel lets the master
    // present them in either order
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;
    assign do_write      = aw_held & w_held & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // read is taken only with no data pending, answered next cycle
    // a master that holds rready low therefore stalls further reads,
    // which is the intended back-pressure
    assign s_axi_arready = ~rvalid_q;
    assign do_read       = s_axi_arvalid & ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // address decode, shared by both directions
    // lane 0 carries bits 7:0, flags included; lane 1 carries bits 10:8.
    // lanes 2 and 3 reach nothing, so a full-word write is always safe
    assign wr_sel     = reg_sel(aw_addr_q);
    assign rd_sel     = reg_sel(s_axi_araddr);
    assign wr_ctrl_lo = do_write & wr_sel[0] & w_strb_q[0];
    assign wr_ctrl_hi = do_write & wr_sel[0] & w_strb_q[1];
    assign wr_mask    = do_write & wr_sel[1] & w_strb_q[0];

    // comparator result after polarity; edges only count while enabled
    // edges are judged after polarity, so with the invert bit set a rise of
    // the raw decision is reported as a falling edge of the output
    assign enabled = comparator_control_status.comparator_enable_bit;
    assign result  = raw_sync
                   ^ comparator_control_status.output_polarity_invert;
    assign flag_set[`CMPC_BIT_RISE] = enabled & result & ~result_prev;
    assign flag_set[`CMPC_BIT_FALL] = enabled & ~result & result_prev;

    // sticky flags: a set in the same cycle as a clear wins, so no edge
    // is ever lost to a late acknowledge
    // software clears by writing ones on lane 0; zeros leave a flag alone
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_flag
            assign flag_clr[gi]  = wr_ctrl_lo & w_data_q[gi];
            assign next_flag[gi] = (comparator_control_status[gi]
                                   & ~flag_clr[gi])
                                   | flag_set[gi];
        end
    endgenerate

    // configuration fields follow their byte lanes
    // the flags are not part of these slices; they have their own
    // set and clear logic above
    assign next_cfg_hi = wr_ctrl_hi
                       ? w_data_q[`CMPC_BIT_EN:`CMPC_BIT_NSEL_LO]
                       : comparator_control_status[`CMPC_BIT_EN:`CMPC_BIT_NSEL_LO];
    assign next_cfg_lo = wr_ctrl_lo
                       ? w_data_q[`CMPC_BIT_ROUTE_HI:`CMPC_BIT_HYST]
                       : comparator_control_status[`CMPC_BIT_ROUTE_HI:`CMPC_BIT_HYST];

    // reserved top bits are forced to zero whatever is written
    // storing them would cost flops and let software see stale values;
    // the constant zero is dropped by synthesis
    assign next_ctrl = cmpc_ctrl_t'({`CMPC_RSV_ZERO,
                                     next_cfg_hi,
                                     next_cfg_lo,
                                     next_flag});

    // mask holds only the two flag positions
    // a set mask bit lets the matching flag reach the interrupt
    assign next_mask = wr_mask ? w_data_q[1:0] : irq_mask;

    // read data: the register sits in the low half, upper bits zero
    // unmapped words read as zero; the response code flags the miss
    assign read_word = rd_sel[0] ? {16'h0000, comparator_control_status}
                     : rd_sel[1] ? {30'h0000_0000, irq_mask}
                     : 32'h0000_0000;

    // routing decode; reserved codes drive neither path
    // so a stray reserved code quietens both outputs rather than guessing
    assign route_pin = (comparator_control_status.output_routing_select
                        == CMPC_ROUTE_PIN);
    assign route_irq = (comparator_control_status.output_routing_select
                        == CMPC_ROUTE_IRQ);

    // interrupt is a level while any unmasked flag stands and the
    // result is routed to the interrupt request
    // masking a flag hides it from the line but leaves it set for polling
    assign irq = route_irq
               & |(comparator_control_status[1:0] & irq_mask);

    // settings for the analog core straight from the register
    // reserved select and response codes are passed on unchanged; the
    // core must cope with them, and software must not use them
    assign analog_cfg.comparator_enable_bit = enabled;
    assign analog_cfg.positive_input_share  = enabled;
    assign analog_cfg.negative_input_select =
        comparator_control_status.negative_input_select;
    assign analog_cfg.response_time_select  =
        comparator_control_status.response_time_select;
    assign analog_cfg.hysteresis_enable     =
        comparator_control_status.hysteresis_enable;

    // the pad follows its own flop directly
    assign comparator_output_pin = pin_q;

    // two-stage synchroniser for the asynchronous comparator decision
    // the analog decision can change at any time; two flops bring it into
    // the aclk domain at the cost of two cycles of latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_meta <= 1'b0;
            raw_sync <= 1'b0;
        end else begin
            raw_meta <= comparator_raw;
            raw_sync <= raw_meta;
        end
    end

    // edge history; it also follows while disabled so that enabling
    // does not fake an edge, though a polarity flip does count as one
    // after reset the history is low, matching a low result
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_prev <= 1'b0;
        end else begin
            result_prev <= result;
        end
    end

    // register file
    // all fields update every cycle from their next values; the write
    // enables are folded into the next-value selection above
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comparator_control_status <= cmpc_ctrl_t'(`CMPC_CTRL_RESET);
            irq_mask                  <= `CMPC_MASK_RESET;
        end else begin
            comparator_control_status <= next_ctrl;
            irq_mask                  <= next_mask;
        end
    end

    // pin shows the result only when enabled and routed there
    // a disabled or rerouted comparator leaves the pad low, not floating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= route_pin & enabled & result;
        end
    end

    // write address holding stage
    // the address is kept until the write is done so the decode and the
    // response code see the same value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held   <= 1'b0;
            aw_addr_q <= 32'h0000_0000;
        end else if (s_axi_awvalid & ~aw_held) begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held   <= 1'b0;
        end
    end

    // write data holding stage
    // data and strobes are held together for the same reason
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held   <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid & ~w_held) begin
            w_held   <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (do_write) begin
            w_held   <= 1'b0;
        end
    end

    // write response; unmapped addresses are answered with SLVERR
    // a new write is held back while a response waits, so no answer is
    // ever overwritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `CMPC_RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (|wr_sel) ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read response; unmapped addresses return zero with SLVERR
    // data are captured at acceptance and stand until rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `CMPC_RESP_OKAY;
        end else if (do_read) begin
            rvalid_q <= 1'b1;
            rdata_q  <= read_word;
            rresp_q  <= (|rd_sel) ? `CMPC_RESP_OKAY : `CMPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : cmpc_top

// ### tb/cmpc_sva.sv
/* checker for cmpc_top: bus timing, read-back and output gating
   assumes binding to the cmpc_top ports and the single aclk domain */
`timescale 1ns/1ps
module cmpc_sva
    import cmpc_pkg::*;
(
    input wire logic                  aclk,          // clock
    input wire logic                  aresetn,       // reset, low
    input wire logic                  s_axi_awvalid, // aw valid
    input wire logic                  s_axi_awready, // aw ready
    input wire logic                  s_axi_wvalid,  // w valid
    input wire logic                  s_axi_wready,  // w ready
    input wire logic [1:0]            s_axi_bresp,   // b code
    input wire logic                  s_axi_bvalid,  // b valid
    input wire logic                  s_axi_bready,  // b ready
    input wire logic [31:0]           s_axi_araddr,  // ar address
    input wire logic                  s_axi_arvalid, // ar valid
    input wire logic                  s_axi_arready, // ar ready
    input wire logic [31:0]           s_axi_rdata,   // r data
    input wire logic [1:0]            s_axi_rresp,   // r code
    input wire logic                  s_axi_rvalid,  // r valid
    input wire logic                  s_axi_rready,  // r ready
    input wire cmpc_pkg::cmpc_analog_t analog_cfg,   // core settings
    input wire logic                  comparator_output_pin, // pin
    input wire logic                  irq            // interrupt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // handshakes seen at the same edge
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs  = s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;

    a_write_latency: assert property (
        aw_hs && w_hs && !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write answer not on time");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_read_latency: assert property (
        ar_hs |=> s_axi_rvalid) else $error("read answer late");
    a_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_ar_blocked: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("address taken while busy");
    a_unmapped_read: assert property (
        ar_hs && s_axi_araddr > 32'h7 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_reserved_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:11] == 21'h0) else $error("reserved bits set");
    a_share_enable: assert property (
        analog_cfg.positive_input_share == analog_cfg.comparator_enable_bit)
        else $error("positive input share differs from enable");
    a_pin_disabled: assert property (
        !analog_cfg.comparator_enable_bit && !$past(analog_cfg.comparator_enable_bit)
        |-> !comparator_output_pin) else $error("pin high while disabled");

    // main scenarios reached
    c_irq: cover property (irq);
    c_pin: cover property (comparator_output_pin);
    c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : cmpc_sva

bind cmpc_top cmpc_sva i_cmpc_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .analog_cfg, .comparator_output_pin, .irq);

// ### tb/tb_cmpc_top.sv
/* bench for cmpc_top: register access, fields, edge flags, interrupt, pin
   assumes cmpc_pkg and cmpc_regs.svh are compiled and on the include path */
`timescale 1ns/1ps
`include "cmpc_regs.svh"
module tb_cmpc_top;
    import cmpc_pkg::*;
    localparam logic [31:0] CTRL = `CMPC_OFF_CTRL;
    localparam logic [31:0] MASK = `CMPC_OFF_MASK;
    localparam logic [1:0]  OK   = `CMPC_RESP_OKAY;
    localparam logic [1:0]  ERR  = `CMPC_RESP_SLVERR;
    logic         aclk    = 1'h0;
    logic         aresetn = 1'h0;
    logic [31:0]  awaddr  = 32'h0;
    logic [31:0]  wdata   = 32'h0;
    logic [31:0]  araddr  = 32'h0;
    logic         awvalid = 1'h0;
    logic         wvalid  = 1'h0;
    logic         bready  = 1'h0;
    logic         arvalid = 1'h0;
    logic         rready  = 1'h0;
    logic         raw     = 1'h0;
    logic [3:0]   strb    = 4'hF;
    logic         awready, wready, bvalid, arready, rvalid, pin, irq;
    logic [1:0]   bresp, rresp;
    logic [31:0]  rdata;
    cmpc_analog_t cfg;
    int           bad_count = 0;
    int           checked   = 0;
    int           cycles    = 0;

    cmpc_top i_cmpc_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .comparator_raw(raw), .analog_cfg(cfg), .comparator_output_pin(pin), .irq(irq)
    );

    // 200 MHz clock
    initial forever #2.5 aclk = ~aclk;

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            test_done;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // the requests above land only after this time step, so the loop
        // waits for an edge before it looks at them
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bready && bvalid) begin
                bready <= 1'h0;
                chk(32'(bresp), 32'(er), "bresp");
            end
        end while (awvalid || wvalid || bready);
    endtask : wr

    // read and judge data and response code at the edge where rvalid is seen
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rready && rvalid) begin
                rready <= 1'h0;
                chk(rdata, e, "rdata");
                chk(32'(rresp), 32'(er), "rresp");
            end
        end while (arvalid || rready);
    endtask : rd

    // the input needs two sync stages plus one edge to reach the flags and pin
    task automatic edge_in(input logic v);
        raw <= v;
        repeat (4) @(posedge aclk);
    endtask : edge_in

    task automatic t_reset;
        rd(CTRL, 32'h0, OK);
        rd(MASK, 32'h0, OK);
        chk(32'(cfg), 32'h0, "cfg");
        chk({30'h0, pin, irq}, 32'h0, "pin irq");
    endtask : t_reset

    // every code of select, response and hysteresis, reserved ones included
    task automatic t_fields;
        wr(CTRL, 32'hFFFF_FFDC, OK);
        rd(CTRL, 32'h0000_07DC, OK);
        for (int i = 0; i < 4; i++) begin
            int d;
            d = 32'h400 | (i << 8) | (i << 3) | ((i & 1) << 2);
            wr(CTRL, d, OK);
            rd(CTRL, d, OK);
            chk(32'(cfg), 32'h60 | (i << 3) | (i << 1) | (i & 1), "cfg");
        end
        // single byte lanes: lane 0 reaches bits 7:0 only, lane 1 bits 10:8
        strb <= 4'h1;
        wr(CTRL, 32'h0, OK);
        rd(CTRL, 32'h0000_0700, OK);
        strb <= 4'h2;
        wr(CTRL, 32'h0000_00FF, OK);
        rd(CTRL, 32'h0, OK);
        strb <= 4'hF;
        wr(CTRL, 32'h0, OK);
        chk(32'(cfg), 32'h0, "cfg off");
    endtask : t_fields

    task automatic t_unmapped;
        wr(32'h8, 32'hFFFF, ERR);
        rd(32'h8, 32'h0, ERR);
        rd(CTRL, 32'h0, OK);
    endtask : t_unmapped

    // sticky flags, write-one clear, mask and interrupt level
    task automatic t_flags;
        wr(MASK, 32'h3, OK);
        rd(MASK, 32'h3, OK);
        wr(CTRL, 32'h4C0, OK);
        chk(32'(irq), 32'h0, "irq idle");
        edge_in(1'h1);
        rd(CTRL, 32'h4C2, OK);
        chk(32'(irq), 32'h1, "irq rise");
        wr(CTRL, 32'h4C0, OK);
        rd(CTRL, 32'h4C2, OK);
        wr(MASK, 32'h1, OK);
        chk(32'(irq), 32'h0, "irq masked");
        wr(MASK, 32'h3, OK);
        wr(CTRL, 32'h4C2, OK);
        rd(CTRL, 32'h4C0, OK);
        chk(32'(irq), 32'h0, "irq cleared");
        edge_in(1'h0);
        rd(CTRL, 32'h4C1, OK);
        chk(32'(irq), 32'h1, "irq fall");
        wr(CTRL, 32'h4C0, OK);
        rd(CTRL, 32'h4C1, OK);
        wr(CTRL, 32'h4C1, OK);
        rd(CTRL, 32'h4C0, OK);
        chk(32'(irq), 32'h0, "irq end");
    endtask : t_flags

    // pin routing, polarity and disable
    task automatic t_pin;
        wr(CTRL, 32'h480, OK);
        edge_in(1'h1);
        chk(32'(pin), 32'h1, "pin high");
        chk(32'(irq), 32'h0, "no irq on pin route");
        wr(CTRL, 32'h4A0, OK);
        repeat (3) @(posedge aclk);
        chk(32'(pin), 32'h0, "pin inverted");
        edge_in(1'h0);
        chk(32'(pin), 32'h1, "pin inverted low");
        wr(CTRL, 32'h0A0, OK);
        repeat (3) @(posedge aclk);
        chk(32'(pin), 32'h0, "pin disabled");
    endtask : t_pin

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // reset for ten cycles, then the scenarios in turn
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_fields;
        t_unmapped;
        t_flags;
        t_pin;
        test_done;
    end
endmodule : tb_cmpc_top
